// ===== logic/olac_core.sv
// output lock and alarm control: decides whether the dc output may be on
// assumes panel pulses and measurements come from logic on aclk
//
// Functional notes
// RL1: standby on, output off: switch-on allowed
// RL2: standby off: refuse switch-on, flag refusal
// RL3: standby on, output on: user toggles freely
// RL4: standby falls while on: off and locked
// RL5: standby returning on re-enables locked output
// RL6: user action during lock cancels pin request
// RL7: analog remote active while select pin low
// RL8: any alarm switches the output off
// RL9: ack clears latched alarm only without cause
// RL10: power fail, overtemperature clear by themselves
// RL11: manual ack by enter or on press
// RL12: remote ack by standby off then on
// RL13: digital ack by error read or command
// RL14: overvoltage at threshold, limit 1.1 nominal
// RL15: overcurrent at threshold trips output off
// RL16: overpower at threshold, limit 1.1 nominal
// RL17: thresholds reset to 110 percent
// RL18: power fail trips off, restore configurable
// RL19: overtemperature trips off, restore configurable
// RL20: alarms indicated, buzzer only if enabled
// RL21: per-alarm counts from zero at reset
// RL22: sound setting applied on confirm only
// RL23: under remote, standby pin alone rules output
// RL24: alarm pins group thermal/supply and protection
// RL25: effective standby is pin xor invert
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module olac_core
	import olac_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// register bus
	input  wire olac_pkg::olac_axi_req_t axi_req,
	output olac_pkg::olac_axi_rsp_t      axi_rsp,
	// interface pins (asynchronous)
	input  wire logic              standby_pin,
	input  wire logic              remote_sel_n,
	input  wire logic              ac_fail,
	input  wire logic              overtemp,
	// front panel and measurement
	input  wire olac_pkg::olac_panel_t   panel,
	input  wire olac_pkg::olac_meas_t    meas,
	// indication
	output olac_pkg::olac_ind_t          ind
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		// bus slave
		logic                          awready;
		logic                          wready;
		logic                          arready;
		logic                          aw_have;
		logic [7:0]                    aw_addr;
		logic                          w_have;
		logic [31:0]                   w_data;
		logic [3:0]                    w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
		// configuration
		logic                          invert;
		logic                          sound;
		logic                          sound_pend;
		logic                          pf_restore;
		logic                          ot_restore;
		logic [OLAC_MEAS_W-1:0]        thr_v;
		logic [OLAC_MEAS_W-1:0]        thr_i;
		logic [OLAC_MEAS_W-1:0]        thr_p;
		// output control
		logic                          eff_q;
		logic                          out_on;
		logic                          pin_lock;
		logic                          pin_req;
		logic                          restore_pend;
		logic                          refused;
		logic [OLAC_NUM_AL-1:0]        alarm;
		logic [OLAC_NUM_AL*OLAC_CNT_W-1:0] count;
		olac_ind_t                     ind;
	} olac_state_t;

	// released standby and remote-select pins sit high: no false remote or edge after reset
	localparam logic [3:0] PIN_IDLE = 4'h3;

	olac_state_t s_q;
	olac_state_t s_d;
	logic [3:0]  sync_q;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	olac_sync #(
		.W   (4),
		.RST (PIN_IDLE)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({overtemp, ac_fail, remote_sel_n, standby_pin}),
		.q       (sync_q)
	);

	// byte-lane merge of a 16-bit field
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	function automatic logic [15:0] clamp16(input logic [15:0] v);
		return (v > OLAC_THR_LIMIT) ? OLAC_THR_LIMIT : v;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic                   eff;
	logic                   remote;
	logic                   eff_rise;
	logic                   eff_fall;
	logic                   cmd_on;
	logic                   cmd_off;
	logic                   dig_ack;
	logic                   ack;
	logic                   user;
	logic                   on_try;
	logic                   refuse;
	logic                   any_alarm;
	logic                   old_alarm;
	logic [OLAC_NUM_AL-1:0] cause;
	logic [OLAC_NUM_AL-1:0] fresh;
	logic [OLAC_CNT_W-1:0]  cnt;

	always_comb begin
		s_d = s_q;
		cmd_on = 1'b0;
		cmd_off = 1'b0;
		dig_ack = 1'b0;
		refuse = 1'b0;
		cnt = '0;
		eff = sync_q[0] ^ s_q.invert; // RL25
		remote = ~sync_q[1]; // RL7
		eff_rise = eff & ~s_q.eff_q;
		eff_fall = ~eff & s_q.eff_q;
		s_d.eff_q = eff;

		// write channel
		if (axi_req.awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = axi_req.wdata;
			s_d.w_strb = axi_req.wstrb;
		end
		if (s_q.bvalid && axi_req.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = OLAC_RESP_OKAY;
			case (s_q.aw_addr)
				OLAC_REG_CTRL: begin
					if (s_q.w_strb[0]) begin
						s_d.invert = s_q.w_data[OLAC_CTRL_INV];
						s_d.sound_pend = s_q.w_data[OLAC_CTRL_SOUND];
						s_d.pf_restore = s_q.w_data[OLAC_CTRL_PF_RST];
						s_d.ot_restore = s_q.w_data[OLAC_CTRL_OT_RST];
					end
				end
				OLAC_REG_CMD: begin
					if (s_q.w_strb[0]) begin
						cmd_on = s_q.w_data[OLAC_CMD_ON];
						cmd_off = s_q.w_data[OLAC_CMD_OFF];
						dig_ack = s_q.w_data[OLAC_CMD_ACK];
						if (s_q.w_data[OLAC_CMD_CONFIRM]) begin
							s_d.sound = s_q.sound_pend; // RL22
						end else if (s_q.w_data[OLAC_CMD_CANCEL]) begin
							s_d.sound_pend = s_q.sound; // RL22
						end
					end
				end
				OLAC_REG_THR_V: begin
					s_d.thr_v = clamp16(merge16(s_q.thr_v, s_q.w_data, s_q.w_strb)); // RL14
				end
				OLAC_REG_THR_I: begin
					s_d.thr_i = merge16(s_q.thr_i, s_q.w_data, s_q.w_strb);
				end
				OLAC_REG_THR_P: begin
					s_d.thr_p = clamp16(merge16(s_q.thr_p, s_q.w_data, s_q.w_strb)); // RL16
				end
				OLAC_REG_STATUS, OLAC_REG_ERR, OLAC_REG_CNT_A, OLAC_REG_CNT_B: begin
					s_d.bresp = OLAC_RESP_OKAY;
				end
				default: begin
					s_d.bresp = OLAC_RESP_SLVERR;
				end
			endcase
		end

		// read channel
		if (s_q.rvalid && axi_req.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_req.arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = OLAC_RESP_OKAY;
			s_d.rdata = '0;
			case (axi_req.araddr)
				OLAC_REG_CTRL: begin
					s_d.rdata[OLAC_CTRL_INV] = s_q.invert;
					s_d.rdata[OLAC_CTRL_SOUND] = s_q.sound_pend;
					s_d.rdata[OLAC_CTRL_PF_RST] = s_q.pf_restore;
					s_d.rdata[OLAC_CTRL_OT_RST] = s_q.ot_restore;
				end
				OLAC_REG_CMD: begin
					s_d.rdata[OLAC_CMD_CONFIRM] = s_q.sound;
				end
				OLAC_REG_STATUS: begin
					s_d.rdata[11:0] = {s_q.alarm, s_q.refused, s_q.sound,
						remote, s_q.eff_q, s_q.pin_req, s_q.pin_lock,
						s_q.out_on}; // RL20
				end
				OLAC_REG_ERR: begin
					// reading the error buffer acknowledges alarms
					s_d.rdata[5:0] = {s_q.refused, s_q.alarm};
					dig_ack = 1'b1; // RL13
					s_d.refused = 1'b0;
				end
				OLAC_REG_THR_V: begin
					s_d.rdata[OLAC_MEAS_W-1:0] = s_q.thr_v;
				end
				OLAC_REG_THR_I: begin
					s_d.rdata[OLAC_MEAS_W-1:0] = s_q.thr_i;
				end
				OLAC_REG_THR_P: begin
					s_d.rdata[OLAC_MEAS_W-1:0] = s_q.thr_p;
				end
				OLAC_REG_CNT_A: begin
					s_d.rdata = s_q.count[4*OLAC_CNT_W-1:0];
				end
				OLAC_REG_CNT_B: begin
					s_d.rdata[OLAC_CNT_W-1:0] = s_q.count[OLAC_NUM_AL*OLAC_CNT_W-1 -: OLAC_CNT_W];
				end
				default: begin
					s_d.rresp = OLAC_RESP_SLVERR;
				end
			endcase
		end

		// ------------------------------------------------------------
		// alarms
		// ------------------------------------------------------------
		cause[OLAC_AL_OV] = meas.volt >= s_q.thr_v; // RL14
		cause[OLAC_AL_OC] = meas.curr >= s_q.thr_i; // RL15
		cause[OLAC_AL_OP] = meas.power >= s_q.thr_p; // RL16
		cause[OLAC_AL_PF] = sync_q[2]; // RL18
		cause[OLAC_AL_OT] = sync_q[3]; // RL19
		old_alarm = |s_q.alarm;
		ack = dig_ack; // RL13
		if (!remote && (panel.enter || (panel.onoff && old_alarm))) begin
			ack = 1'b1; // RL11
		end
		if (remote && eff_rise) begin
			ack = 1'b1; // RL12
		end
		for (int i = 0; i < OLAC_NUM_PROT; i++) begin
			// a present cause keeps the latch set against the ack
			s_d.alarm[i] = cause[i] | (s_q.alarm[i] & ~ack); // RL9
		end
		s_d.alarm[OLAC_AL_PF] = cause[OLAC_AL_PF]; // RL10
		s_d.alarm[OLAC_AL_OT] = cause[OLAC_AL_OT]; // RL10
		fresh = s_d.alarm & ~s_q.alarm;
		for (int i = 0; i < OLAC_NUM_AL; i++) begin
			cnt = s_q.count[i*OLAC_CNT_W +: OLAC_CNT_W];
			if (fresh[i] && cnt != OLAC_CNT_MAX) begin
				s_d.count[i*OLAC_CNT_W +: OLAC_CNT_W] = cnt + 8'h01; // RL21
			end
		end
		any_alarm = |s_d.alarm;

		// ------------------------------------------------------------
		// output control
		// ------------------------------------------------------------
		user = (panel.onoff && !old_alarm) || cmd_on || cmd_off;
		on_try = (!remote && panel.onoff && !old_alarm && !s_q.out_on) || cmd_on;
		if (remote) begin
			s_d.out_on = eff; // RL23
			s_d.pin_lock = 1'b0;
			s_d.pin_req = 1'b0;
		end else begin
			if (s_q.pin_lock && user) begin
				s_d.pin_req = 1'b0; // RL6
			end
			if (s_q.out_on) begin
				if (eff_fall) begin
					s_d.out_on = 1'b0; // RL4
					s_d.pin_lock = 1'b1;
					s_d.pin_req = 1'b1;
				end else if (cmd_off || (panel.onoff && !old_alarm)) begin
					s_d.out_on = 1'b0; // RL3
				end
			end else if (eff_rise && s_q.pin_lock) begin
				s_d.pin_lock = 1'b0;
				s_d.pin_req = 1'b0;
				s_d.out_on = s_q.pin_req && !user; // RL5
			end else if (on_try) begin
				if (eff) begin
					s_d.out_on = 1'b1; // RL1
				end else begin
					refuse = 1'b1; // RL2
				end
			end
		end

		// supply and thermal trips may restore the output afterwards
		if ((fresh[OLAC_AL_PF] && s_q.pf_restore) || (fresh[OLAC_AL_OT] && s_q.ot_restore)) begin
			if (s_q.out_on || s_q.restore_pend) begin
				s_d.restore_pend = 1'b1; // RL18 RL19
			end
		end
		if (s_q.restore_pend && !any_alarm) begin
			s_d.restore_pend = 1'b0;
			s_d.out_on = eff; // RL18 RL19
		end
		if (any_alarm) begin
			if (on_try && !remote) begin
				refuse = 1'b1;
			end
			s_d.out_on = 1'b0; // RL8
		end
		if (refuse) begin
			s_d.refused = 1'b1; // RL2
		end

		// ------------------------------------------------------------
		// indication and bus ready flags
		// ------------------------------------------------------------
		s_d.ind.dc_on = s_d.out_on;
		s_d.ind.alarm_pin1 = s_d.alarm[OLAC_AL_PF] | s_d.alarm[OLAC_AL_OT]; // RL24
		s_d.ind.alarm_pin2 = |s_d.alarm[OLAC_NUM_PROT-1:0]; // RL24
		s_d.ind.buzzer = any_alarm & s_d.sound; // RL20
		s_d.ind.alarms = s_d.alarm; // RL20
		s_d.ind.refused = refuse; // RL2
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready = !s_d.w_have && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.thr_v <= OLAC_THR_DEFAULT; // RL17
			s_q.thr_i <= OLAC_THR_DEFAULT; // RL17
			s_q.thr_p <= OLAC_THR_DEFAULT; // RL17
			s_q.eff_q <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign axi_rsp.awready = s_q.awready;
	assign axi_rsp.wready  = s_q.wready;
	assign axi_rsp.bvalid  = s_q.bvalid;
	assign axi_rsp.bresp   = s_q.bresp;
	assign axi_rsp.arready = s_q.arready;
	assign axi_rsp.rvalid  = s_q.rvalid;
	assign axi_rsp.rdata   = s_q.rdata;
	assign axi_rsp.rresp   = s_q.rresp;
	assign ind             = s_q.ind;

endmodule

// ===== logic/olac_pkg.sv
// output lock and alarm control: shared constants and carrier types
// assumes one 40 MHz clock domain and an AXI4-Lite master with 8-bit addresses
package olac_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OLAC_REG_CTRL   = 8'h00;
	localparam logic [7:0] OLAC_REG_CMD    = 8'h04;
	localparam logic [7:0] OLAC_REG_STATUS = 8'h08;
	localparam logic [7:0] OLAC_REG_ERR    = 8'h0C;
	localparam logic [7:0] OLAC_REG_THR_V  = 8'h10;
	localparam logic [7:0] OLAC_REG_THR_I  = 8'h14;
	localparam logic [7:0] OLAC_REG_THR_P  = 8'h18;
	localparam logic [7:0] OLAC_REG_CNT_A  = 8'h20;
	localparam logic [7:0] OLAC_REG_CNT_B  = 8'h24;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OLAC_CTRL_INV     = 0;
	localparam int OLAC_CTRL_SOUND   = 1;
	localparam int OLAC_CTRL_PF_RST  = 2;
	localparam int OLAC_CTRL_OT_RST  = 3;
	localparam int OLAC_CMD_ON       = 0;
	localparam int OLAC_CMD_OFF      = 1;
	localparam int OLAC_CMD_ACK      = 2;
	localparam int OLAC_CMD_CONFIRM  = 3;
	localparam int OLAC_CMD_CANCEL   = 4;

	// alarm vector order
	localparam int OLAC_AL_OV  = 0;
	localparam int OLAC_AL_OC  = 1;
	localparam int OLAC_AL_OP  = 2;
	localparam int OLAC_AL_PF  = 3;
	localparam int OLAC_AL_OT  = 4;
	localparam int OLAC_NUM_AL = 5;
	localparam int OLAC_NUM_PROT = 3;

	// ----------------------------------------------------------------
	// thresholds and counters
	// ----------------------------------------------------------------
	localparam int OLAC_MEAS_W = 16;
	localparam int OLAC_CNT_W  = 8;
	// full scale code of the measurement inputs at nominal value
	localparam int OLAC_NOM     = 10000;
	localparam int OLAC_PCT_THR = 110;
	localparam logic [OLAC_MEAS_W-1:0] OLAC_THR_DEFAULT =
		OLAC_MEAS_W'(OLAC_NOM * OLAC_PCT_THR / 100);
	localparam logic [OLAC_MEAS_W-1:0] OLAC_THR_LIMIT = OLAC_THR_DEFAULT;
	localparam logic [OLAC_CNT_W-1:0] OLAC_CNT_MAX = 8'hFF;

	localparam logic [1:0] OLAC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] OLAC_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} olac_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} olac_axi_rsp_t;

	typedef struct packed {
		logic [OLAC_MEAS_W-1:0] volt;
		logic [OLAC_MEAS_W-1:0] curr;
		logic [OLAC_MEAS_W-1:0] power;
	} olac_meas_t;

	typedef struct packed {
		logic onoff;
		logic enter;
	} olac_panel_t;

	typedef struct packed {
		logic                   dc_on;
		logic                   alarm_pin1;
		logic                   alarm_pin2;
		logic                   buzzer;
		logic                   refused;
		logic [OLAC_NUM_AL-1:0] alarms;
	} olac_ind_t;

endpackage

// ===== logic/olac_sync.sv
// output lock and alarm control: two-stage synchroniser for pin inputs
// assumes the inputs are asynchronous levels and stable for several clocks
`timescale 1ns/1ps
module olac_sync #(
	parameter int           W   = 1,
	// reset value of both stages, set to the idle level of each pin
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= RST;
			q      <= RST;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ===== tb/olac_props.sv
// checker for the output lock and alarm control block
// assumes it is bound to olac_core and sees only its ports
`timescale 1ns/1ps
module olac_props
	import olac_pkg::*;
(
	// clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// register bus
	input wire olac_pkg::olac_axi_req_t axi_req,
	input wire olac_pkg::olac_axi_rsp_t axi_rsp,
	// interface pins
	input wire logic                    standby_pin,
	input wire logic                    remote_sel_n,
	input wire logic                    ac_fail,
	input wire logic                    overtemp,
	// panel, measurement, indication
	input wire olac_pkg::olac_panel_t   panel,
	input wire olac_pkg::olac_meas_t    meas,
	input wire olac_pkg::olac_ind_t     ind
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_alarm_forces_off: assert property ((|ind.alarms) [*2] |-> !ind.dc_on)
		else $error("output on during alarm");
	a_ov_trip: assert property (meas.volt >= OLAC_THR_LIMIT |-> ##[1:2] ind.alarms[OLAC_AL_OV])
		else $error("overvoltage not raised");
	a_op_trip: assert property (meas.power >= OLAC_THR_LIMIT |-> ##[1:2] ind.alarms[OLAC_AL_OP])
		else $error("overpower not raised");
	a_ov_held: assert property (ind.alarms[OLAC_AL_OV] && meas.volt >= OLAC_THR_LIMIT
		|=> ind.alarms[OLAC_AL_OV])
		else $error("alarm cleared with cause present");
	a_pf_trip: assert property (ac_fail [*5] |-> ind.alarms[OLAC_AL_PF] && !ind.dc_on)
		else $error("power fail not raised");
	a_pf_selfclear: assert property ((!ac_fail) [*5] |-> !ind.alarms[OLAC_AL_PF])
		else $error("power fail alarm stuck");
	a_pin_groups: assert property ((|ind.alarms[2:0]) [*2] |-> ind.alarm_pin2)
		else $error("second alarm pin low");
	a_buzzer_cause: assert property (ind.buzzer |-> (|ind.alarms) || (|$past(ind.alarms)))
		else $error("buzzer without alarm");
	a_refused_off: assert property (ind.refused |-> !ind.dc_on)
		else $error("refusal while output on");
endmodule

bind olac_core olac_props olac_props_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .standby_pin(standby_pin), .remote_sel_n(remote_sel_n),
	.ac_fail(ac_fail), .overtemp(overtemp), .panel(panel), .meas(meas), .ind(ind));

// ===== tb/olac_pin_model.sv
// external controller on the standby and remote-select pins
// assumes open-collector drivers to ground with pull-ups on both pins
`timescale 1ns/1ps
module olac_pin_model (
	// clock
	input wire logic aclk,
	// pins
	output logic     standby_pin,
	output logic     remote_sel_n
);
	logic sb_low;
	logic rem_low;

	// released pins are pulled high
	assign standby_pin  = !sb_low;
	assign remote_sel_n = !rem_low;
	initial begin
		sb_low  = 1'b0;
		rem_low = 1'b0;
	end

	task automatic set_sb(input logic lvl);
		@(posedge aclk);
		sb_low <= !lvl;
	endtask

	task automatic set_rem(input logic lvl);
		@(posedge aclk);
		rem_low <= !lvl;
	endtask

	// off level, then back to on level
	task automatic ack_toggle(input logic inv);
		set_sb(inv);
		repeat (5) @(posedge aclk);
		set_sb(!inv);
	endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the output lock and alarm control block
// assumes olac_core with its bound checker and the pin model
`timescale 1ns/1ps
module tb;
	import olac_pkg::*;
	logic          aclk, aresetn, ac_fail, overtemp, standby_pin, remote_sel_n;
	olac_axi_req_t req;
	olac_axi_rsp_t rsp;
	olac_panel_t   panel;
	olac_meas_t    meas;
	olac_ind_t     ind;
	int            err_count, n_compared, n_ref, seed, exp_on, exp_al, k, n;
	int            cnt[5];
	logic [31:0]   d;
	logic [15:0]   th, th_i;
	logic [3:0]    strb;

	olac_core olac_core_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.standby_pin(standby_pin), .remote_sel_n(remote_sel_n), .ac_fail(ac_fail),
		.overtemp(overtemp), .panel(panel), .meas(meas), .ind(ind));
	olac_pin_model pin_inst (.aclk(aclk), .standby_pin(standby_pin), .remote_sel_n(remote_sel_n));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(negedge aclk) if (ind.refused === 1'b1) n_ref++;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			$display("[ERR] %s expected %h seen %h", nm, ex, seen);
			err_count++;
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic cmp_out();
		@(negedge aclk);
		chk("dc_on", ind.dc_on, exp_on);
		chk("alarms", ind.alarms, exp_al);
		chk("pin1", ind.alarm_pin1, |exp_al[4:3]);
		chk("pin2", ind.alarm_pin2, |exp_al[2:0]);
		@(posedge aclk);
	endtask

	task automatic wt();
		repeat (6) @(posedge aclk);
	endtask

	logic [3:0] strb_q;
	function automatic logic [7:0] strb_hi(input logic [15:0] o);
		return strb_q[1] ? 8'hFF : o[15:8];
	endfunction
	function automatic logic [7:0] strb_lo(input logic [15:0] o);
		return strb_q[0] ? 8'hFF : o[7:0];
	endfunction

	task automatic press(input bit ent);
		if (ent) panel.enter <= 1'b1;
		else panel.onoff <= 1'b1;
		@(posedge aclk);
		panel <= '0;
		repeat (3) @(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// bus master
	// ----------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		bit         done;
		int         t;
		logic       hw, hd, hb;
		logic [1:0] r;
		done = 0;
		t = 0;
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= strb;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!done && t < 50) begin
			@(negedge aclk);
			hw = req.awvalid & rsp.awready;
			hd = req.wvalid & rsp.wready;
			hb = rsp.bvalid === 1'b1;
			r = rsp.bresp;
			@(posedge aclk);
			if (hw) req.awvalid <= 1'b0;
			if (hd) req.wvalid <= 1'b0;
			if (hb) begin
				req.bready <= 1'b0;
				chk("bresp", r, er);
				done = 1;
			end
			t++;
		end
		if (!done) chk("bus_wait", 0, 1);
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		bit         done;
		int         t;
		logic       ha, hr;
		logic [1:0] r;
		done = 0;
		t = 0;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!done && t < 50) begin
			@(negedge aclk);
			ha = req.arvalid & rsp.arready;
			hr = rsp.rvalid === 1'b1;
			r = rsp.rresp;
			v = rsp.rdata;
			@(posedge aclk);
			if (ha) req.arvalid <= 1'b0;
			if (hr) begin
				req.rready <= 1'b0;
				chk("rresp", r, er);
				done = 1;
			end
			t++;
		end
		if (!done) chk("bus_wait", 0, 1);
		@(posedge aclk);
	endtask

	initial begin
		#2000000;
		err_count++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 3863;
		strb = 4'hF;
		aresetn = 1'b0;
		req = '0;
		panel = '0;
		meas = '0;
		ac_fail = 1'b0;
		overtemp = 1'b0;
		exp_on = 0;
		exp_al = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		for (k = 0; k < 3; k++) begin
			axr(OLAC_REG_THR_V + 8'(4 * k), d, OLAC_RESP_OKAY);
			chk("thr_reset", d, 32'(OLAC_NOM * 110 / 100));
		end
		axr(OLAC_REG_CNT_A, d, OLAC_RESP_OKAY);
		chk("cnt_reset", d, 0);
		axr(8'hC0, d, OLAC_RESP_SLVERR);
		axw(8'hC0, 32'h1, OLAC_RESP_SLVERR);
		pin_inst.set_sb(1'b0);
		wt();
		n = n_ref;
		press(0);
		axw(OLAC_REG_CMD, 32'h1, OLAC_RESP_OKAY);
		chk("refused", n_ref - n, 2);
		cmp_out();
		pin_inst.set_sb(1'b1);
		wt();
		press(0);
		exp_on = 1;
		cmp_out();
		press(0);
		exp_on = 0;
		cmp_out();
		axw(OLAC_REG_CMD, 32'h1, OLAC_RESP_OKAY);
		exp_on = 1;
		cmp_out();
		axw(OLAC_REG_CMD, 32'h2, OLAC_RESP_OKAY);
		exp_on = 0;
		cmp_out();
		axw(OLAC_REG_CMD, 32'h1, OLAC_RESP_OKAY);
		exp_on = 1;
		cmp_out();
		pin_inst.set_sb(1'b0);
		wt();
		exp_on = 0;
		cmp_out();
		pin_inst.set_sb(1'b1);
		wt();
		exp_on = 1;
		cmp_out();
		pin_inst.set_sb(1'b0);
		wt();
		press(0);
		exp_on = 0;
		pin_inst.set_sb(1'b1);
		wt();
		cmp_out();
		// inverted polarity: high pin now asks for off
		axw(OLAC_REG_CTRL, 32'h1, OLAC_RESP_OKAY);
		n = n_ref;
		press(0);
		chk("refused_inv", n_ref - n, 1);
		pin_inst.set_sb(1'b0);
		wt();
		press(0);
		exp_on = 1;
		cmp_out();
		press(0);
		exp_on = 0;
		axw(OLAC_REG_CTRL, 32'h0, OLAC_RESP_OKAY);
		pin_inst.set_sb(1'b1);
		wt();
		for (k = 0; k < 3; k++) begin
			th = 16'(1000 + {$random(seed)} % 9000);
			if (k == 1) th_i = th;
			axw(OLAC_REG_THR_V + 8'(4 * k), {16'h0, th}, OLAC_RESP_OKAY);
			axw(OLAC_REG_CMD, 32'h1, OLAC_RESP_OKAY);
			meas <= olac_meas_t'({32'h0, th} << (16 * (2 - k)));
			wt();
			exp_al = 1 << k;
			cnt[k]++;
			cmp_out();
			press(1);
			cmp_out();
			meas <= '0;
			wt();
			cmp_out();
			if (k == 0) press(1);
			else if (k == 1) press(0);
			else begin
				axr(OLAC_REG_ERR, d, OLAC_RESP_OKAY);
				chk("err_buf", d[4:0], 32'h4);
			end
			exp_al = 0;
			cmp_out();
		end
		axw(OLAC_REG_THR_V, 32'hFFFF, OLAC_RESP_OKAY);
		axr(OLAC_REG_THR_V, d, OLAC_RESP_OKAY);
		chk("thr_clamp", d, 32'(OLAC_NOM * 110 / 100));
		strb_q = 4'h0;
		// random byte strobes on the current threshold: the check expects neither lane to change
		strb = 4'($random(seed));
		axw(OLAC_REG_THR_I, 32'hFFFFFFFF, OLAC_RESP_OKAY);
		strb = 4'hF;
		axr(OLAC_REG_THR_I, d, OLAC_RESP_OKAY);
		chk("thr_strb", d, {16'h0, strb_hi(th_i), strb_lo(th_i)});
		meas <= '1;
		wt();
		for (k = 0; k < 3; k++) cnt[k]++;
		exp_al = 7;
		cmp_out();
		axr(OLAC_REG_STATUS, d, OLAC_RESP_OKAY);
		chk("status", d[11:7], exp_al);
		meas <= '0;
		wt();
		axw(OLAC_REG_CMD, 32'h4, OLAC_RESP_OKAY);
		exp_al = 0;
		cmp_out();
		axr(OLAC_REG_CNT_A, d, OLAC_RESP_OKAY);
		chk("cnt_a", d, {8'(cnt[3]), 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])});
		// restore bit of one trip kind must not act on the other kind
		for (k = 0; k < 4; k++) begin
			axw(OLAC_REG_CTRL, k[1] ? 32'h8 : 32'h4, OLAC_RESP_OKAY);
			axw(OLAC_REG_CMD, 32'h1, OLAC_RESP_OKAY);
			if (k[0]) overtemp <= 1'b1;
			else ac_fail <= 1'b1;
			wt();
			exp_on = 0;
			exp_al = 8 << k[0];
			cnt[3 + k[0]]++;
			cmp_out();
			ac_fail <= 1'b0;
			overtemp <= 1'b0;
			wt();
			exp_on = (k == 0 || k == 3);
			exp_al = 0;
			cmp_out();
		end
		axr(OLAC_REG_CNT_B, d, OLAC_RESP_OKAY);
		chk("cnt_b", d, cnt[4]);
		for (k = 0; k < 2; k++) begin
			axw(OLAC_REG_CTRL, 32'h2, OLAC_RESP_OKAY);
			axw(OLAC_REG_CMD, (k == 1) ? 32'h8 : 32'h10, OLAC_RESP_OKAY);
			ac_fail <= 1'b1;
			wt();
			@(negedge aclk);
			chk("buzzer", ind.buzzer, k);
			@(posedge aclk);
			ac_fail <= 1'b0;
			wt();
		end
		exp_on = 0;
		pin_inst.set_rem(1'b0);
		wt();
		exp_on = 1;
		cmp_out();
		press(0);
		cmp_out();
		meas.volt <= 16'hFFFF;
		wt();
		meas <= '0;
		exp_on = 0;
		exp_al = 1;
		cmp_out();
		pin_inst.ack_toggle(1'b0);
		wt();
		exp_on = 1;
		exp_al = 0;
		cmp_out();
		print_verdict();
	end
endmodule
